// ### include/mfi_pkg.sv
// Package for the multifunction input decoder: function codes, widths, fields.
// Assumes a single 100 MHz control clock and an APB register bus.
`default_nettype none
package mfi_pkg;
  localparam int NUM_INPUTS = 7;
  localparam logic [7:0] CODE_EXT_FAULT_BASE = 8'h20;
  localparam logic [7:0] CODE_EXT_FAULT_LAST = 8'h2f;
  localparam logic [7:0] CODE_INTEG_RESET = 8'h30;
  localparam logic [7:0] CODE_INTEG_HOLD = 8'h31;
  localparam logic [7:0] CODE_RAMP_BYPASS = 8'h34;
  localparam logic [7:0] CODE_ERROR_INVERT = 8'h35;
  localparam logic [7:0] CODE_OPTION_SOURCE = 8'h36;
  localparam logic [7:0] CODE_PREHEAT = 8'h60;
  localparam logic [7:0] CODE_SEARCH_MAX = 8'h61;
  localparam logic [7:0] CODE_SEARCH_CMD = 8'h62;
  localparam logic [7:0] CODE_SEARCH_BLOCK = 8'h64;
  localparam logic [7:0] CODE_LOOP_TEST = 8'h67;
  localparam int FLT_SENSE_BIT = 0;
  localparam int FLT_WINDOW_BIT = 1;
  localparam int FLT_REACT_LSB = 2;
  localparam logic [1:0] REACT_DECEL = 2'h0;
  localparam logic [1:0] REACT_COAST = 2'h1;
  localparam logic [1:0] REACT_FAST = 2'h2;
  localparam logic [1:0] REACT_CONTINUE = 2'h3;
  localparam logic [1:0] SEARCH_ESTIMATE = 2'h0;
  localparam logic [1:0] SEARCH_CURRENT = 2'h2;
  localparam logic [1:0] SOURCE_TERMINALS = 2'h1;
  // Register byte offsets
  localparam logic [7:0] ADDR_FUNC_LO = 8'h00;
  localparam logic [7:0] ADDR_FUNC_HI = 8'h04;
  localparam logic [7:0] ADDR_SETTINGS = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_FAULTS = 8'h10;
  localparam logic [7:0] ADDR_FAULT_CLR = 8'h14;
  // Field positions in the settings register
  localparam int SET_SEARCH_LSB = 0;
  localparam int SET_SEARCH_ALL_BIT = 2;
  localparam int SET_REF_SRC_LSB = 4;
  localparam int SET_RUN_SRC_LSB = 6;
  localparam int SET_PREHEAT_LSB = 8;
  // Reset values
  localparam logic [31:0] FUNC_LO_RESET = 32'h00000000;
  // Seventh input powers up holding the loopback self-test code
  localparam logic [31:0] FUNC_HI_RESET = 32'h00670000;
  localparam logic [15:0] SETTINGS_RESET = 16'h0050;
  // Loopback test
  localparam logic [7:0] LOOP_PATTERN = 8'ha5;
  localparam int LOOP_BITS = 8;
  localparam int LOOP_WAIT_NS = 100;
  localparam int LOOP_WAIT_CYC = (LOOP_WAIT_NS + 9) / 10;
endpackage
`default_nettype wire

// ### verilog/mfi_loop_test.sv
// Serial loopback self-test: shifts a pattern out and compares what returns.
// Assumes tx is wired back to rx externally; rx_sync is already synchronised.
`default_nettype none
module mfi_loop_test
  import mfi_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic start,
  input wire logic rx_sync,
  output logic tx,
  output logic done,
  output logic pass
);
  typedef enum logic [1:0] {LT_IDLE, LT_SEND, LT_WAIT, LT_DONE} mfi_lt_e;
  typedef struct packed {
    mfi_lt_e st;
    logic [3:0] bitn;
    logic [3:0] wait_cnt;
    logic [7:0] got;
    logic tx;
    logic ok;
  } mfi_lt_s;
  mfi_lt_s s, next_s;

  always_comb
  begin
    next_s = s;
    case (s.st)
      LT_IDLE:
      begin
        next_s.tx = 1'b1;
        if (start)
        begin
          next_s.st = LT_SEND;
          next_s.bitn = 4'h0;
          next_s.tx = LOOP_PATTERN[0];
          next_s.wait_cnt = 4'h0;
        end
      end
      LT_SEND:
      begin
        // Wait for the bit to pass the pin and the synchroniser
        if (s.wait_cnt == 4'(LOOP_WAIT_CYC))
        begin
          next_s.wait_cnt = 4'h0;
          next_s.got = {rx_sync, s.got[7:1]};
          if (s.bitn == 4'(LOOP_BITS - 1))
            next_s.st = LT_WAIT;
          else
          begin
            next_s.bitn = s.bitn + 4'h1;
            next_s.tx = LOOP_PATTERN[3'(s.bitn + 4'h1)];
          end
        end
        else
          next_s.wait_cnt = s.wait_cnt + 4'h1;
      end
      LT_WAIT:
      begin
        next_s.tx = 1'b1;
        next_s.ok = (s.got == LOOP_PATTERN);
        next_s.st = LT_DONE;
      end
      LT_DONE: next_s.st = LT_DONE;
      default: next_s.st = LT_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      s <= '{LT_IDLE, 4'h0, 4'h0, 8'h00, 1'b1, 1'b0};
    else
      s <= next_s;
  end

  assign tx = s.tx;
  assign done = (s.st == LT_DONE);
  assign pass = s.ok;

  chk_done_stable: assert property (@(posedge clock) disable iff (!rstn) done |=> done)
    else $error("self-test done dropped");
endmodule
`default_nettype wire

// ### verilog/mfi_decoder.sv
// Multifunction input decoder: maps seven contact inputs by function code onto drive control.
// Assumes contacts are asynchronous pins, run/stop status comes from drive logic on this clock.
//
// The implementer's own choices: the APB register port and the address map.
`default_nettype none
module mfi_decoder
  import mfi_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_INPUTS-1:0] contact_in,
  input wire logic run_cmd,
  input wire logic running,
  input wire logic start_req,
  input wire logic serial_rx,
  output logic serial_tx,
  output logic fault_decel,
  output logic fault_coast,
  output logic fault_fast,
  output logic fault_minor,
  output logic integ_zero,
  output logic integ_freeze,
  output logic ramp_bypass,
  output logic error_invert,
  output logic source_option,
  output logic preheat_on,
  output logic [7:0] preheat_level,
  output logic output_block,
  output logic search_go,
  output logic search_from_max,
  output logic search_current,
  output logic comm_alarm,
  output logic fault_contact,
  output logic test_pass
);
  typedef struct packed {
    logic [NUM_INPUTS-1:0] sync1;
    logic [NUM_INPUTS-1:0] sync2;
    logic rx1;
    logic rx2;
    logic [55:0] func;
    logic [15:0] settings;
    logic test_mode;
    logic strap_taken;
    logic [3:0] ext_stat;
    logic srch_prev;
    logic blk_prev;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] flt;
    logic zero;
    logic freeze;
    logic bypass;
    logic inv;
    logic src_opt;
    logic heat;
    logic [7:0] heat_lvl;
    logic blk;
    logic go;
    logic from_max;
    logic cur;
    logic alarm;
    logic fcont;
    logic pass;
  } mfi_st_s;
  mfi_st_s s, next_s;
  logic [NUM_INPUTS-1:0] act [0:15];
  logic [3:0] fault_hit;
  logic [NUM_INPUTS-1:0] flt_cfg;
  logic lt_tx, lt_done, lt_pass;

  // Per-input decode: one bit per function per input, collected for OR-reduction
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi = gi + 1)
    begin : g_in
      logic [7:0] code;
      logic closed;
      logic is_fault;
      logic seen;
      assign code = s.func[gi*8 +: 8];
      assign closed = s.sync2[gi];
      assign is_fault = (code >= CODE_EXT_FAULT_BASE) && (code <= CODE_EXT_FAULT_LAST);
      assign flt_cfg[gi] = is_fault;
      // Contact sense and detection window of an external fault
      assign seen = is_fault && (closed ^ code[FLT_SENSE_BIT])
                    && (!code[FLT_WINDOW_BIT] || running);
      for (genvar r = 0; r < 4; r = r + 1)
      begin : g_r
        assign act[r][gi] = seen && (code[FLT_REACT_LSB +: 2] == 2'(r));
      end
      assign act[4][gi] = closed && code == CODE_INTEG_RESET;
      assign act[5][gi] = closed && code == CODE_INTEG_HOLD;
      assign act[6][gi] = closed && code == CODE_RAMP_BYPASS;
      assign act[7][gi] = closed && code == CODE_ERROR_INVERT;
      assign act[8][gi] = code == CODE_OPTION_SOURCE;
      assign act[9][gi] = closed && code == CODE_OPTION_SOURCE;
      assign act[10][gi] = closed && code == CODE_PREHEAT;
      assign act[11][gi] = closed && code == CODE_SEARCH_MAX;
      assign act[12][gi] = closed && code == CODE_SEARCH_CMD;
      assign act[13][gi] = code == CODE_SEARCH_BLOCK;
      assign act[14][gi] = closed && code == CODE_SEARCH_BLOCK;
      assign act[15][gi] = 1'b0;
    end
  endgenerate

  assign fault_hit = {|act[REACT_CONTINUE], |act[REACT_FAST], |act[REACT_COAST], |act[REACT_DECEL]};

  mfi_loop_test u_loop (
    .clock(clock),
    .rstn(rstn),
    .start(s.test_mode),
    .rx_sync(s.rx2),
    .tx(lt_tx),
    .done(lt_done),
    .pass(lt_pass)
  );

  always_comb
  begin
    logic src_terms;
    logic want_opt;
    logic srch_in;
    logic blk_in;
    logic [1:0] meth;
    src_terms = 1'b0;
    want_opt = 1'b0;
    srch_in = 1'b0;
    blk_in = 1'b0;
    meth = 2'h0;
    next_s = s;
    next_s.sync1 = contact_in;
    next_s.sync2 = s.sync1;
    next_s.rx1 = serial_rx;
    next_s.rx2 = s.rx1;
    // Seventh input strap caught once after reset release
    if (!s.strap_taken)
    begin
      next_s.strap_taken = 1'b1;
      next_s.test_mode = (s.func[(NUM_INPUTS-1)*8 +: 8] == CODE_LOOP_TEST);
    end
    // APB slave, zero-wait answer: ready in the access cycle
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    if (psel && !penable)
    begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h00000000;
      case (paddr)
        ADDR_FUNC_LO: next_s.prdata = s.func[31:0];
        ADDR_FUNC_HI: next_s.prdata = {8'h00, s.func[55:32]};
        ADDR_SETTINGS: next_s.prdata = {16'h0000, s.settings};
        ADDR_STATUS: next_s.prdata = {19'h00000, s.sync2, s.test_mode, lt_done, s.pass, s.alarm,
                                      s.src_opt, s.heat};
        ADDR_FAULTS: next_s.prdata = {28'h0000000, s.ext_stat};
        ADDR_FAULT_CLR: next_s.prdata = 32'h00000000;
        default: next_s.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && s.pready && pwrite && !s.pslverr)
    begin
      case (paddr)
        ADDR_FUNC_LO: next_s.func[31:0] = pwdata;
        ADDR_FUNC_HI: next_s.func[55:32] = pwdata[23:0];
        ADDR_SETTINGS: next_s.settings = pwdata[15:0];
        ADDR_FAULT_CLR: next_s.ext_stat = s.ext_stat & ~pwdata[3:0];
        default: next_s.settings = s.settings;
      endcase
    end
    // Sticky fault record: a new fault wins over a clear
    next_s.ext_stat = next_s.ext_stat | fault_hit;
    next_s.flt = fault_hit;
    next_s.zero = |act[4];
    next_s.freeze = (|act[5]) && !(|act[4]);
    next_s.bypass = |act[6];
    next_s.inv = |act[7];
    src_terms = (s.settings[SET_REF_SRC_LSB +: 2] == SOURCE_TERMINALS)
                && (s.settings[SET_RUN_SRC_LSB +: 2] == SOURCE_TERMINALS);
    want_opt = (|act[8]) && src_terms && !(|act[9]);
    if (!running)
      next_s.src_opt = want_opt;
    next_s.heat = (|act[10]) && !run_cmd;
    next_s.heat_lvl = s.settings[SET_PREHEAT_LSB +: 8];
    blk_in = |act[13];
    next_s.blk = blk_in && !(|act[14]);
    next_s.blk_prev = |act[14];
    srch_in = (|act[11]) || (|act[12]);
    next_s.srch_prev = srch_in;
    next_s.go = (start_req && (srch_in || s.settings[SET_SEARCH_ALL_BIT]))
                || ((|act[14]) && !s.blk_prev);
    next_s.from_max = |act[11];
    meth = s.settings[SET_SEARCH_LSB +: 2];
    next_s.cur = (meth == SEARCH_CURRENT);
    if (lt_done && s.test_mode)
    begin
      next_s.alarm = !lt_pass;
      next_s.fcont = !lt_pass;
      next_s.pass = lt_pass;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s <= '0;
      s.func <= {FUNC_HI_RESET[23:0], FUNC_LO_RESET};
      s.settings <= SETTINGS_RESET;
    end
    else
      s <= next_s;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      serial_tx <= 1'b1;
    else
      serial_tx <= s.test_mode ? lt_tx : 1'b1;
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign {fault_minor, fault_fast, fault_coast, fault_decel} = s.flt;
  assign integ_zero = s.zero;
  assign integ_freeze = s.freeze;
  assign ramp_bypass = s.bypass;
  assign error_invert = s.inv;
  assign source_option = s.src_opt;
  assign preheat_on = s.heat;
  assign preheat_level = s.heat_lvl;
  assign output_block = s.blk;
  assign search_go = s.go;
  assign search_from_max = s.from_max;
  assign search_current = s.cur;
  assign comm_alarm = s.alarm;
  assign fault_contact = s.fcont;
  assign test_pass = s.pass;

  chk_reset_wins: assert property (@(posedge clock) disable iff (!rstn) !(integ_zero && integ_freeze))
    else $error("integral reset and hold both active");
  chk_src_stopped: assert property (@(posedge clock) disable iff (!rstn)
    running && $past(running) |-> $stable(source_option))
    else $error("source changed while running");
  chk_heat_run: assert property (@(posedge clock) disable iff (!rstn)
    $past(run_cmd) |-> !preheat_on)
    else $error("preheat during run");
  chk_fault_cfg: assert property (@(posedge clock) disable iff (!rstn)
    (fault_minor || fault_fast || fault_coast || fault_decel) |-> $past(|flt_cfg))
    else $error("fault raised with no fault code");
  chk_block_search: assert property (@(posedge clock) disable iff (!rstn)
    output_block |-> !$past(|act[14]))
    else $error("output blocked with contact closed");
  chk_alarm_pass: assert property (@(posedge clock) disable iff (!rstn) !(comm_alarm && test_pass))
    else $error("alarm and pass together");
  chk_bypass_follow: assert property (@(posedge clock) disable iff (!rstn)
    ramp_bypass == $past(|act[6]))
    else $error("ramp bypass lag wrong");
  chk_invert_follow: assert property (@(posedge clock) disable iff (!rstn)
    error_invert == $past(|act[7]))
    else $error("error invert lag wrong");
  cov_fault: cover property (@(posedge clock) fault_decel);
  cov_heat: cover property (@(posedge clock) preheat_on);
  cov_search: cover property (@(posedge clock) search_go);
  cov_test: cover property (@(posedge clock) test_pass);
endmodule
`default_nettype wire

// ### testbench/mfi_field.sv
// Field side model: contact bank and the strapped serial loopback.
// Assumes the bench sets the wanted contact states at a rising clock edge.
`default_nettype none
module mfi_field
(
  input wire logic clock,
  input wire logic [6:0] want,
  input wire logic cut,
  input wire logic tx,
  output logic [6:0] contacts,
  output logic rx
);
  timeunit 1ns;
  timeprecision 1ps;
  // Contacts settle one clock after the bench asks
  always @(posedge clock)
  begin
    contacts <= want;
  end
  // Send and receive lines wired together; cut inverts the return to force a failed self-test
  assign rx = tx ^ cut;
endmodule
`default_nettype wire

// ### testbench/test_multifunction_input_decoder.sv
// Self-checking bench for the multifunction input decoder.
// Assumes the decoder package and the field model are compiled first.
`default_nettype none
module test_multifunction_input_decoder import mfi_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rstn, psel, penable, pwrite, pready, pslverr, run_cmd, running, start_req;
  logic [7:0] paddr, preheat_level, lvl;
  logic [31:0] pwdata, prdata, rdat, d;
  logic serial_rx, serial_tx, rerr, k, r, cut;
  logic [6:0] contact_in, want;
  logic fault_decel, fault_coast, fault_fast, fault_minor, integ_zero, integ_freeze, ramp_bypass;
  logic error_invert, source_option, preheat_on, output_block, search_go, search_from_max;
  logic search_current, comm_alarm, fault_contact, test_pass;
  logic [2:0] tab [6];
  int err_total, checks_done, pulses;

  mfi_decoder u_dut (.clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .contact_in, .run_cmd, .running, .start_req, .serial_rx, .serial_tx, .fault_decel,
    .fault_coast, .fault_fast, .fault_minor, .integ_zero, .integ_freeze, .ramp_bypass, .error_invert,
    .source_option, .preheat_on, .preheat_level, .output_block, .search_go, .search_from_max,
    .search_current, .comm_alarm, .fault_contact, .test_pass);
  mfi_field u_field (.clock, .want, .cut, .tx(serial_tx), .contacts(contact_in), .rx(serial_rx));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
    if (n >= 50)
    begin
      err_total++;
      end_sim();
    end
  endtask

  // Waits out contact latency, counting search pulses on the way
  task automatic settle();
    pulses = 0;
    repeat (6)
    begin
      @(posedge clock);
      pulses += int'(search_go === 1'b1);
    end
  endtask

  function automatic logic [3:0] exp_flt(logic [7:0] c, logic kk, logic rr);
    return ((kk ^ c[0]) && (!c[1] || rr)) ? (4'h1 << c[3:2]) : 4'h0;
  endfunction

  initial
  begin
    {rstn, psel, penable, pwrite, run_cmd, running, start_req} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    want = 7'h00;
    cut = 1'b0;
    d = $urandom(32'hf97d5427);
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    apb(1'b0, ADDR_SETTINGS, 32'h0);
    chk(rdat, 32'(SETTINGS_RESET));
    apb(1'b0, ADDR_FUNC_LO, 32'h0);
    chk(rdat, FUNC_LO_RESET);
    apb(1'b0, ADDR_FUNC_HI, 32'h0);
    chk(rdat, FUNC_HI_RESET);
    d = $urandom & 32'h001f1f1f;
    apb(1'b1, ADDR_FUNC_HI, d);
    apb(1'b0, ADDR_FUNC_HI, 32'h0);
    chk(rdat, d);
    apb(1'b1, ADDR_FUNC_HI, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(rerr), 32'h1);
    $display("test registers done");
    for (int c = 32; c < 48; c++)
    begin
      repeat (3)
      begin
        k = 1'($urandom_range(1));
        r = 1'($urandom_range(1));
        running <= r;
        want[0] <= k;
        apb(1'b1, ADDR_FUNC_LO, 32'(c));
        settle();
        chk(32'({fault_minor, fault_fast, fault_coast, fault_decel}), 32'(exp_flt(8'(c), k, r)));
      end
    end
    running <= 1'b0;
    want[0] <= 1'b1;
    apb(1'b1, ADDR_FUNC_LO, 32'(CODE_EXT_FAULT_BASE));
    settle();
    apb(1'b1, ADDR_FAULT_CLR, 32'hf);
    apb(1'b0, ADDR_FAULTS, 32'h0);
    chk(rdat, 32'h1);
    want[0] <= 1'b0;
    settle();
    apb(1'b1, ADDR_FAULT_CLR, 32'hf);
    apb(1'b0, ADDR_FAULTS, 32'h0);
    chk(rdat, 32'h0);
    $display("test faults done");
    chk(32'({test_pass, comm_alarm, fault_contact}), 32'h4);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(rdat[5:2]), 32'he);
    $display("test selftest done");
    apb(1'b1, ADDR_FUNC_LO, 32'h35343130);
    for (int v = 0; v < 16; v++)
    begin
      want[3:0] <= 4'(v);
      settle();
      chk(32'({integ_zero, integ_freeze, ramp_bypass, error_invert}),
        32'({v[0], v[1] & ~v[0], v[2], v[3]}));
    end
    want <= 7'h00;
    $display("test integral done");
    // Rows are running, contact, expected option source
    tab = '{3'b001, 3'b010, 3'b100, 3'b001, 3'b111, 3'b010};
    apb(1'b1, ADDR_FUNC_LO, 32'(CODE_OPTION_SOURCE));
    foreach (tab[i])
    begin
      running <= tab[i][2];
      want[0] <= tab[i][1];
      settle();
      chk(32'(source_option), 32'(tab[i][0]));
    end
    running <= 1'b0;
    $display("test source done");
    lvl = 8'($urandom);
    apb(1'b1, ADDR_SETTINGS, {16'h0, lvl, 8'h50});
    apb(1'b1, ADDR_FUNC_LO, 32'(CODE_PREHEAT));
    // Rows are run command, contact, expected injection
    tab = '{3'b011, 3'b110, 3'b011, 3'b000, 3'b100, 3'b011};
    foreach (tab[i])
    begin
      run_cmd <= tab[i][2];
      want[0] <= tab[i][1];
      settle();
      chk(32'({preheat_on, preheat_on ? preheat_level : 8'h00}), 32'({tab[i][0], tab[i][0] ? lvl : 8'h00}));
    end
    want[0] <= 1'b0;
    $display("test preheat done");
    for (int m = 0; m < 4; m += 2)
    begin
      for (int c = 97; c < 99; c++)
      begin
        apb(1'b1, ADDR_SETTINGS, 32'h50 | 32'(m));
        apb(1'b1, ADDR_FUNC_LO, 32'(c));
        want[0] <= 1'b1;
        start_req <= 1'b1;
        settle();
        chk(32'({search_go, search_from_max, search_current}), 32'({1'b1, c == 97, m == 2}));
        want[0] <= 1'b0;
        settle();
        chk(32'(search_go), 32'h0);
        start_req <= 1'b0;
      end
    end
    apb(1'b1, ADDR_SETTINGS, 32'h54);
    start_req <= 1'b1;
    settle();
    chk(32'(search_go), 32'h1);
    start_req <= 1'b0;
    apb(1'b1, ADDR_FUNC_LO, 32'(CODE_SEARCH_BLOCK));
    settle();
    chk(32'(output_block), 32'h1);
    want[0] <= 1'b1;
    settle();
    chk(32'({output_block, 8'(pulses)}), 32'h1);
    $display("test search done");
    cut <= 1'b1;
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    repeat (150) @(posedge clock);
    chk(32'({test_pass, comm_alarm, fault_contact}), 32'h3);
    $display("test failed loop done");
    end_sim();
  end
endmodule
`default_nettype wire
